/* File: design/cebt_defines.vh */
// Constants for the CAN error counter and bit timing block
// Overview of operation
// - Receive and transmit error counters, eight bits each, packed in one 16-bit register.
// - Software reads both counters at any time through the error count register.
// - Receiver bit error while sending an active error flag adds 8.
// - Receiver adds 8 when first bit after its error flag is dominant.
// - Dominant bits after flags: 14th or 8th adds 8, then every further 8.
// - Other errors add 1 to receive counter, 8 to transmit counter.
// - Valid reception or transmission subtracts 1, never below zero.
// - Transmitter bit error while sending an active error flag adds 8.
// - Arbitration stuff error on own recessive stuff bit leaves transmit counter.
// - Passive acknowledge error without dominant bit in flag leaves transmit counter.
// - Each bit is sync segment, first time segment, second time segment.
// - Sync segment lasts exactly one quantum; edges expected inside it.
// - First segment length in quanta comes from a 4-bit field.
// - Second segment length in quanta comes from a 3-bit field.
// - Jump width bounds bit adjustment; resync only on recessive-to-dominant edges.
// - Falling edge on idle bus hard synchronizes and restarts bit timing.
// - Phase error: zero in sync, positive in first, negative in second segment.
// - Phase error magnitude within jump width acts like hard synchronization.
// - Phase error above jump width lengthens first segment by jump width.
// - Phase error below minus jump width shortens second segment by jump width.
// - Quantum clock is input clock divided by the prescaler value.
// - Bit rate is clock over prescaler times one plus both segments.
// - Error passive above 127 on either counter; active when both below 128.
// - Bus off with bus output disabled when transmit counter passes 255.
// - Bus off ends after 128 runs of 11 recessive bits, counters cleared.
// - Error warning shown; left when both counters are below 96.
`ifndef CEBT_DEFINES_VH
`define CEBT_DEFINES_VH

// Register indices
`define CEBT_ADDR_W        4
`define CEBT_DATA_W        16
`define CEBT_REG_ERRCNT    4'h0
`define CEBT_REG_TIMING    4'h1
`define CEBT_REG_STATUS    4'h2

// Timing register fields
`define CEBT_TS2_LSB       0
`define CEBT_TS2_MSB       2
`define CEBT_TS1_LSB       3
`define CEBT_TS1_MSB       6
`define CEBT_SJW_LSB       7
`define CEBT_SJW_MSB       8
`define CEBT_PSC_LSB       9
`define CEBT_PSC_MSB       14
`define CEBT_TIMING_RST    16'h0A3D

// Counter thresholds
`define CEBT_CNT_MAX       8'hFF
`define CEBT_PASSIVE_LIM   8'h7F
`define CEBT_WARN_LIM      8'h60
`define CEBT_ADD_BIG       6'h08
`define CEBT_ADD_ONE       6'h01
`define CEBT_DOM_ACTIVE    5'h0E
`define CEBT_DOM_PASSIVE   5'h08
`define CEBT_RCS_RUN       4'hB
`define CEBT_RCS_SEQS      8'h80

`endif

/* File: design/cebt_core.v */
// CAN error counters, error state and bit time logic
`timescale 1ns/10ps
`default_nettype none
`include "cebt_defines.vh"

module cebt_core (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        sys_rst,
   // Register port
   input  wire [3:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata_r,
   // CAN bus pins
   input  wire        can_rx,
   output reg         can_tx_r,
   // Protocol engine events
   input  wire        is_transmitter,
   input  wire        bus_idle,
   input  wire        tx_bit,
   input  wire        ev_flag_bit_err,
   input  wire        ev_err_flag_end,
   input  wire        ev_ovl_flag_end,
   input  wire        flag_passive,
   input  wire        ev_other_err,
   input  wire        ev_arb_stuff_err,
   input  wire        ev_ack_err,
   input  wire        pflag_dom_seen,
   input  wire        ev_valid_rx,
   input  wire        ev_valid_tx,
   // Bit timing and state outputs
   output reg         sample_bit_r,
   output reg         sample_stb_r,
   output reg         err_passive_r,
   output reg         err_warning_r,
   output reg         bus_off_r
);

   localparam [1:0] SEG_SYNC = 2'b00;
   localparam [1:0] SEG_TS1  = 2'b01;
   localparam [1:0] SEG_TS2  = 2'b10;

   // Zero-length field treated as one quantum
   function [4:0] len_eff;
      input [3:0] v;
      begin
         len_eff = (v == 4'h0) ? 5'h01 : {1'b0, v};
      end
   endfunction

   reg  [15:0] timing_r;
   reg  [7:0]  rec_r;
   reg  [7:0]  tec_r;
   reg         rx_m_r;
   reg         rx_s_r;
   reg         rx_prev_r;
   reg  [5:0]  presc_cnt_r;
   reg  [1:0]  seg_r;
   reg  [4:0]  tq_cnt_r;
   reg  [4:0]  ext_r;
   reg  [4:0]  shrt_r;
   reg         resync_done_r;
   reg         dom_act_r;
   reg  [4:0]  dom_cnt_r;
   reg  [4:0]  dom_lim_r;
   reg         first_chk_r;
   reg  [3:0]  rcs_cnt_r;
   reg  [7:0]  seq_cnt_r;

   wire [3:0]  ts1_fld = timing_r[`CEBT_TS1_MSB:`CEBT_TS1_LSB];
   wire [3:0]  ts2_fld = {1'b0, timing_r[`CEBT_TS2_MSB:`CEBT_TS2_LSB]};
   wire [3:0]  sjw_fld = {2'b00, timing_r[`CEBT_SJW_MSB:`CEBT_SJW_LSB]};
   wire [5:0]  psc_fld = timing_r[`CEBT_PSC_MSB:`CEBT_PSC_LSB];
   wire [4:0]  ts1_len = len_eff(ts1_fld);
   wire [4:0]  ts2_len = len_eff(ts2_fld);
   wire [4:0]  sjw_len = len_eff(sjw_fld);
   wire [5:0]  psc_end = (psc_fld == 6'h00) ? 6'h00 : psc_fld - 6'h01;

   wire        tq_tick = (presc_cnt_r >= psc_end);

   wire        fall_edge = rx_prev_r & ~rx_s_r;
   wire        hard_sync = fall_edge & bus_idle;
   wire        soft_edge = fall_edge & ~bus_idle & ~resync_done_r & (seg_r != SEG_SYNC);

   // Phase error in quanta from the sync segment
   wire [4:0]  e_pos = tq_cnt_r + 5'h01;
   wire [4:0]  ts2_act = (ts2_len > shrt_r) ? ts2_len - shrt_r : 5'h01;
   wire [4:0]  e_neg = (ts2_act > tq_cnt_r) ? ts2_act - tq_cnt_r : 5'h01;
   wire [4:0]  e_mag = (seg_r == SEG_TS1) ? e_pos : e_neg;
   // Small phase error restarts the bit
   wire        resync_rst = soft_edge & (e_mag <= sjw_len);
   wire        resync_big = soft_edge & (e_mag > sjw_len);
   wire [4:0]  ts1_lim = ts1_len + ext_r;

   // Bus input synchroniser and edge history
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         rx_m_r    <= 1'b1;
         rx_s_r    <= 1'b1;
         rx_prev_r <= 1'b1;
      end else begin
         rx_m_r    <= can_rx;
         rx_s_r    <= rx_m_r;
         rx_prev_r <= rx_s_r;
      end
   end

   // Bit time sequencer
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         presc_cnt_r   <= 6'h00;
         seg_r         <= SEG_SYNC;
         tq_cnt_r      <= 5'h00;
         ext_r         <= 5'h00;
         shrt_r        <= 5'h00;
         resync_done_r <= 1'b0;
         sample_bit_r  <= 1'b1;
         sample_stb_r  <= 1'b0;
      end else begin
         sample_stb_r <= 1'b0;
         if (hard_sync | resync_rst) begin
            presc_cnt_r   <= 6'h00;
            seg_r         <= SEG_SYNC;
            tq_cnt_r      <= 5'h00;
            ext_r         <= 5'h00;
            shrt_r        <= 5'h00;
            resync_done_r <= 1'b1;
         end else begin
            if (tq_tick) begin
               presc_cnt_r <= 6'h00;
               case (seg_r)
                  SEG_SYNC: begin
                     seg_r         <= SEG_TS1;
                     tq_cnt_r      <= 5'h00;
                     ext_r         <= 5'h00;
                     shrt_r        <= 5'h00;
                     resync_done_r <= 1'b0;
                  end
                  SEG_TS1: begin
                     if (tq_cnt_r + 5'h01 >= ts1_lim) begin
                        seg_r        <= SEG_TS2;
                        tq_cnt_r     <= 5'h00;
                        sample_bit_r <= rx_s_r;
                        sample_stb_r <= 1'b1;
                     end else begin
                        tq_cnt_r <= tq_cnt_r + 5'h01;
                     end
                  end
                  SEG_TS2: begin
                     if (tq_cnt_r + 5'h01 >= ts2_act) begin
                        // Bit of psc times 1 + ts1 + ts2 ends
                        seg_r    <= SEG_SYNC;
                        tq_cnt_r <= 5'h00;
                     end else begin
                        tq_cnt_r <= tq_cnt_r + 5'h01;
                     end
                  end
                  default: begin
                     seg_r    <= SEG_SYNC;
                     tq_cnt_r <= 5'h00;
                  end
               endcase
            end else begin
               presc_cnt_r <= presc_cnt_r + 6'h01;
            end
            if (resync_big) begin
               resync_done_r <= 1'b1;
               if (seg_r == SEG_TS1)
                  ext_r <= sjw_len;
               else
                  shrt_r <= sjw_len;
            end
         end
      end
   end

   // Dominant run tracking after flags
   wire dom_hit = sample_stb_r & dom_act_r & ~sample_bit_r & (dom_cnt_r + 5'h01 >= dom_lim_r);
   wire first_dom = sample_stb_r & first_chk_r & ~sample_bit_r;

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         dom_act_r   <= 1'b0;
         dom_cnt_r   <= 5'h00;
         dom_lim_r   <= `CEBT_DOM_ACTIVE;
         first_chk_r <= 1'b0;
      end else if (ev_err_flag_end | ev_ovl_flag_end) begin
         dom_act_r   <= 1'b1;
         dom_cnt_r   <= 5'h00;
         dom_lim_r   <= (ev_err_flag_end & flag_passive) ? `CEBT_DOM_PASSIVE : `CEBT_DOM_ACTIVE;
         first_chk_r <= ev_err_flag_end;
      end else if (sample_stb_r) begin
         first_chk_r <= 1'b0;
         if (sample_bit_r) begin
            dom_act_r <= 1'b0;
            dom_cnt_r <= 5'h00;
         end else if (dom_hit) begin
            dom_cnt_r <= 5'h00;
            dom_lim_r <= `CEBT_DOM_PASSIVE;
         end else if (dom_act_r) begin
            dom_cnt_r <= dom_cnt_r + 5'h01;
         end
      end
   end

   // Counter increments by role
   reg  [5:0] rx_add;
   reg  [5:0] tx_add;
   always @* begin
      rx_add = 6'h00;
      tx_add = 6'h00;
      if (!is_transmitter) begin
         if (ev_flag_bit_err)
            rx_add = rx_add + `CEBT_ADD_BIG;
         if (first_dom)
            rx_add = rx_add + `CEBT_ADD_BIG;
         if (dom_hit)
            rx_add = rx_add + `CEBT_ADD_BIG;
         if (ev_other_err)
            rx_add = rx_add + `CEBT_ADD_ONE;
      end else begin
         if (ev_flag_bit_err)
            tx_add = tx_add + `CEBT_ADD_BIG;
         if (dom_hit)
            tx_add = tx_add + `CEBT_ADD_BIG;
         if (ev_other_err && !ev_arb_stuff_err && !(ev_ack_err && err_passive_r && !pflag_dom_seen))
            tx_add = tx_add + `CEBT_ADD_BIG;
      end
   end

   wire [8:0] rec_sum = {1'b0, rec_r} + {3'b000, rx_add};
   wire [8:0] tec_sum = {1'b0, tec_r} + {3'b000, tx_add};
   wire       tec_ovf = tec_sum[8];
   wire       rcs_done = sample_stb_r & sample_bit_r & (rcs_cnt_r + 4'h1 >= `CEBT_RCS_RUN);

   // Error counters and bus-off state
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         rec_r     <= 8'h00;
         tec_r     <= 8'h00;
         bus_off_r <= 1'b0;
         rcs_cnt_r <= 4'h0;
         seq_cnt_r <= 8'h00;
      end else if (bus_off_r) begin
         if (sample_stb_r) begin
            if (!sample_bit_r) begin
               rcs_cnt_r <= 4'h0;
            end else if (rcs_done) begin
               rcs_cnt_r <= 4'h0;
               if (seq_cnt_r + 8'h01 >= `CEBT_RCS_SEQS) begin
                  seq_cnt_r <= 8'h00;
                  bus_off_r <= 1'b0;
                  rec_r     <= 8'h00;
                  tec_r     <= 8'h00;
               end else begin
                  seq_cnt_r <= seq_cnt_r + 8'h01;
               end
            end else begin
               rcs_cnt_r <= rcs_cnt_r + 4'h1;
            end
         end
      end else begin
         if (rx_add != 6'h00)
            rec_r <= rec_sum[8] ? `CEBT_CNT_MAX : rec_sum[7:0];
         else if (ev_valid_rx && rec_r != 8'h00)
            rec_r <= rec_r - 8'h01;
         if (tx_add != 6'h00) begin
            tec_r <= tec_ovf ? `CEBT_CNT_MAX : tec_sum[7:0];
            if (tec_ovf) begin
               bus_off_r <= 1'b1;
               rcs_cnt_r <= 4'h0;
               seq_cnt_r <= 8'h00;
            end
         end else if (ev_valid_tx && tec_r != 8'h00) begin
            tec_r <= tec_r - 8'h01;
         end
      end
   end

   // Error state flags and bus driver
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         err_passive_r <= 1'b0;
         err_warning_r <= 1'b0;
         can_tx_r      <= 1'b1;
      end else begin
         // Passive above the limit, dropped as bus off begins
         err_passive_r <= ~bus_off_r & ~tec_ovf & ((rec_r > `CEBT_PASSIVE_LIM) | (tec_r > `CEBT_PASSIVE_LIM));
         // Warning until both below limit, dropped as bus off begins
         err_warning_r <= ~bus_off_r & ~tec_ovf & ((rec_r >= `CEBT_WARN_LIM) | (tec_r >= `CEBT_WARN_LIM));
         can_tx_r      <= bus_off_r | tec_ovf | tx_bit;
      end
   end

   // Register port
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         timing_r    <= `CEBT_TIMING_RST;
         reg_rdata_r <= 16'h0000;
      end else begin
         if (reg_wr && reg_addr == `CEBT_REG_TIMING)
            timing_r <= {1'b0, reg_wdata[`CEBT_PSC_MSB:0]};
         reg_rdata_r <= 16'h0000;
         if (reg_rd) begin
            if (reg_addr == `CEBT_REG_ERRCNT)
               reg_rdata_r <= {tec_r, rec_r};
            else if (reg_addr == `CEBT_REG_TIMING)
               reg_rdata_r <= timing_r;
            else if (reg_addr == `CEBT_REG_STATUS)
               reg_rdata_r <= {9'h000, seg_r, sample_bit_r, rx_s_r, bus_off_r, err_passive_r, err_warning_r};
            else
               reg_rdata_r <= 16'h0000;
         end
      end
   end

endmodule // cebt_core

`default_nettype wire

/* File: testbench/cebt_core_properties.sv */
// Port checks for the error counter and bit timing core
`timescale 1ns/10ps
`default_nettype none
module cebt_core_properties (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   // Register port
   input wire logic [3:0]  reg_addr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata_r,
   // Bus and state
   input wire logic        tx_bit,
   input wire logic        can_tx_r,
   input wire logic        sample_bit_r,
   input wire logic        sample_stb_r,
   input wire logic        err_passive_r,
   input wire logic        err_warning_r,
   input wire logic        bus_off_r
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata_r == 16'h0000)
      else $error("read data not idle");
   chk_rd_unmapped: assert property ($past(reg_rd) && $past(reg_addr) > 4'h2 |-> reg_rdata_r == 16'h0000)
      else $error("unmapped read not zero");
   chk_tx_follow: assert property (!bus_off_r && !$past(bus_off_r) && !$past(sys_rst)
      |-> can_tx_r == $past(tx_bit))
      else $error("bus output does not follow bit");
   chk_tx_off: assert property (bus_off_r && $past(bus_off_r) |-> can_tx_r)
      else $error("bus driven while off");
   chk_stb_pulse: assert property (sample_stb_r |=> !sample_stb_r)
      else $error("sample strobe too long");
   chk_bit_hold: assert property (!sample_stb_r && !$past(sys_rst) |-> $stable(sample_bit_r))
      else $error("sampled bit moved between samples");
   chk_warn_off: assert property (bus_off_r |-> !err_warning_r)
      else $error("warning while off");
   chk_passive_warn: assert property (err_passive_r |-> err_warning_r || bus_off_r)
      else $error("passive without warning");
   chk_off_hold: assert property ($rose(bus_off_r) |-> bus_off_r [*8])
      else $error("bus off left too soon");
endmodule // cebt_core_properties
bind cebt_core cebt_core_properties u_cebt_core_properties (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
   .tx_bit(tx_bit), .can_tx_r(can_tx_r), .sample_bit_r(sample_bit_r), .sample_stb_r(sample_stb_r),
   .err_passive_r(err_passive_r), .err_warning_r(err_warning_r), .bus_off_r(bus_off_r));
`default_nettype wire

/* File: testbench/cebt_bus_node.sv */
// Other nodes on the bus: wired-AND with recessive pull-up
`timescale 1ns/10ps
`default_nettype none
module cebt_bus_node (
   // Other node
   input  wire logic node_bit,
   // Device side
   input  wire logic dut_tx,
   output wire logic can_rx
);
   assign can_rx = node_bit & dut_tx;
endmodule // cebt_bus_node
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the error counter and bit timing core
`timescale 1ns/10ps
`default_nettype none
`include "cebt_defines.vh"
module testbench;
   logic        ref_clk = 1'h0;
   logic        sys_rst = 1'h1;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'h0, reg_rd = 1'h0, node_bit = 1'h1, tx_bit = 1'h1;
   logic        is_transmitter = 1'h0, bus_idle = 1'h0, flag_passive = 1'h0, pflag_dom_seen = 1'h0;
   logic        ev_flag_bit_err = 1'h0, ev_err_flag_end = 1'h0, ev_ovl_flag_end = 1'h0, ev_other_err = 1'h0;
   logic        ev_arb_stuff_err = 1'h0, ev_ack_err = 1'h0, ev_valid_rx = 1'h0, ev_valid_tx = 1'h0;
   wire  [15:0] reg_rdata_r;
   wire         can_rx, can_tx_r, sample_bit_r, sample_stb_r, err_passive_r, err_warning_r, bus_off_r;
   int          err_count = 0, n_compared = 0, cyc = 0, rx_error_count = 0, tx_error_count = 0, boff = 0;
   int          i, n, n2, p, a, b;
   logic [15:0] d;
   logic [31:0] r, seed = 32'h00000041;

   cebt_core u_cebt_core (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .can_rx(can_rx), .can_tx_r(can_tx_r),
      .is_transmitter(is_transmitter), .bus_idle(bus_idle), .tx_bit(tx_bit), .ev_flag_bit_err(ev_flag_bit_err),
      .ev_err_flag_end(ev_err_flag_end), .ev_ovl_flag_end(ev_ovl_flag_end), .flag_passive(flag_passive),
      .ev_other_err(ev_other_err), .ev_arb_stuff_err(ev_arb_stuff_err), .ev_ack_err(ev_ack_err),
      .pflag_dom_seen(pflag_dom_seen), .ev_valid_rx(ev_valid_rx), .ev_valid_tx(ev_valid_tx),
      .sample_bit_r(sample_bit_r), .sample_stb_r(sample_stb_r), .err_passive_r(err_passive_r),
      .err_warning_r(err_warning_r), .bus_off_r(bus_off_r));
   cebt_bus_node u_cebt_bus_node (.node_bit(node_bit), .dut_tx(can_tx_r), .can_rx(can_rx));

   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         results();
      end
   end

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [15:0] tim(input int p, input int a, input int b);
      return {1'h0, p[5:0], 2'h0, a[3:0], b[2:0]};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr(input logic [3:0] ad, input logic [15:0] wd);
      reg_addr <= ad;
      reg_wdata <= wd;
      reg_wr <= 1'h1;
      @(posedge ref_clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] ad, output logic [15:0] rdv);
      reg_addr <= ad;
      reg_rd <= 1'h1;
      @(posedge ref_clk);
      reg_rd <= 1'h0;
      @(posedge ref_clk);
      rdv = reg_rdata_r;
   endtask
   // Cycles up to and including the next sample strobe
   task automatic stb(output int c);
      c = 0;
      do begin
         @(posedge ref_clk);
         c++;
      end while (sample_stb_r !== 1'h1 && c < 500);
   endtask
   // One protocol event, model update, then counter and flag compare
   task automatic ev(input int k, input logic dom);
      logic pas;
      pas = (rx_error_count > 127 || tx_error_count > 127);
      is_transmitter <= (k % 2 == 1) || k == 6;
      ev_other_err <= (k < 2 || k > 5);
      ev_flag_bit_err <= (k == 2 || k == 3);
      ev_valid_rx <= (k == 4);
      ev_valid_tx <= (k == 5);
      ev_ack_err <= (k == 6);
      ev_arb_stuff_err <= (k == 7);
      pflag_dom_seen <= dom;
      if (boff == 0) begin
         if (k == 0) rx_error_count += 1;
         if (k == 2) rx_error_count += 8;
         if (k == 1 || k == 3 || (k == 6 && !(pas && !dom))) tx_error_count += 8;
         if (k == 4 && rx_error_count > 0) rx_error_count -= 1;
         if (k == 5 && tx_error_count > 0) tx_error_count -= 1;
         if (rx_error_count > 255) rx_error_count = 255;
         if (tx_error_count > 255) begin
            tx_error_count = 255;
            boff = 1;
         end
      end
      @(posedge ref_clk);
      {ev_other_err, ev_flag_bit_err, ev_valid_rx, ev_valid_tx, ev_ack_err, ev_arb_stuff_err} <= 6'h00;
      rd(`CEBT_REG_ERRCNT, d);
      check(d, {tx_error_count[7:0], rx_error_count[7:0]});
      pas = (rx_error_count > 127 || tx_error_count > 127) && boff == 0;
      check({13'h0, bus_off_r, err_passive_r & ~bus_off_r, err_warning_r},
         {13'h0, boff[0], pas, (rx_error_count >= 96 || tx_error_count >= 96) && boff == 0});
   endtask

   initial begin
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'h0;
      wr(`CEBT_REG_ERRCNT, 16'hFFFF);
      for (i = 0; i < 3; i++) begin
         rd(i == 2 ? 4'h3 : i[3:0], d);
         check(d, i == 1 ? `CEBT_TIMING_RST : 16'h0000);
      end
      ev(4, 1'h0);
      ev(5, 1'h0);
      for (i = 0; i < 4; i++) begin
         r = rnd();
         p = r[1:0] + 1;
         a = r[7:4] == 0 ? 1 : r[7:4];
         b = r[10:8] == 0 ? 1 : r[10:8];
         wr(`CEBT_REG_TIMING, tim(p, a, b));
         rd(`CEBT_REG_TIMING, d);
         check(d, tim(p, a, b));
         stb(n);
         stb(n);
         stb(n);
         check(n[15:0], p * (1 + a + b));
      end
      wr(`CEBT_REG_TIMING, tim(2, 3, 2));
      bus_idle <= 1'h1;
      stb(n);
      stb(n);
      repeat (5) @(posedge ref_clk);
      node_bit <= 1'h0;
      stb(n);
      check({15'h0, n >= 8 && n <= 14}, 16'h0001);
      check({15'h0, sample_bit_r}, 16'h0000);
      bus_idle <= 1'h0;
      node_bit <= 1'h1;
      repeat (3) stb(n);
      for (i = 0; i < 3; i++) begin
         stb(n);
         is_transmitter <= (i == 1);
         flag_passive <= (i == 1);
         ev_ovl_flag_end <= (i == 2);
         ev_err_flag_end <= (i != 2);
         node_bit <= 1'h0;
         @(posedge ref_clk);
         {ev_ovl_flag_end, ev_err_flag_end} <= 2'h0;
         repeat (20) stb(n);
         node_bit <= 1'h1;
         repeat (3) stb(n);
         if (i == 1) tx_error_count += 16;
         else rx_error_count += (i == 0) ? 16 : 8;
         rd(`CEBT_REG_ERRCNT, d);
         check(d, {tx_error_count[7:0], rx_error_count[7:0]});
      end
      // Late edge in first segment stretches the bit by psc times jump width
      stb(n);
      repeat (5) @(posedge ref_clk);
      node_bit <= 1'h0;
      stb(n);
      check(n[15:0], 16'h0009);
      node_bit <= 1'h1;
      // Early edge in second segment shortens it by the same amount
      stb(n);
      repeat (9) @(posedge ref_clk);
      node_bit <= 1'h0;
      repeat (2) stb(n);
      check(n[15:0], 16'h000A);
      node_bit <= 1'h1;
      // Edge within jump width restarts the bit
      stb(n);
      repeat (3) @(posedge ref_clk);
      node_bit <= 1'h0;
      stb(n);
      check(n[15:0], 16'h000C);
      node_bit <= 1'h1;
      wr(`CEBT_REG_TIMING, tim(1, 2, 1));
      for (i = 0; i < 400 && boff == 0; i++) begin
         r = rnd();
         tx_bit <= r[12];
         ev(r[2:0], r[8]);
      end
      tx_bit <= 1'h1;
      while (boff == 0) ev(1, 1'h0);
      ev(1, 1'h0);
      ev(2, 1'h0);
      n2 = 0;
      while (bus_off_r === 1'h1 && n2 < 1500) begin
         stb(n);
         n2++;
      end
      check({15'h0, n2 >= 1380 && n2 <= 1420}, 16'h0001);
      rd(`CEBT_REG_ERRCNT, d);
      check(d, 16'h0000);
      rd(`CEBT_REG_STATUS, d);
      check(d & 16'h001F, 16'h0018);
      results();
   end
endmodule // testbench
`default_nettype wire
